// [rtl/vfd_host_register_port.sv]
`timescale 1ns/1ps
// Functional notes
// - Strap low selects serial link, strap high selects parallel bus.
// - Parallel transfers are four or eight bits wide, set by configuration.
// - Exactly two eight-bit host registers: command and transfer data.
// - Command register is write only; its read never returns its contents.
// - Command byte is an instruction, possibly carrying a RAM address.
// - Data register writes are copied into the selected RAM automatically.
// - Address command prefetches the addressed RAM byte into the data register.
// - Each data read prefetches the next RAM location.
// - Write with select low loads the command register, M68 or i80 style.
// - Status read gives busy on bit seven, address counter below.
// - Write with select high updates RAM and steps the address counter; the data register keeps its prefetched value.
// - Read with select high returns the prefetched data register.
// - Busy indicator always reads zero.
// - Address command loads the address counter and selects the RAM.
// - Each RAM data access steps the address counter up or down.
module vfd_host_register_port import vhp_pkg::*; (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic interfaceModeStrap,
  input wire logic busStyleI80,
  input wire logic busWidth4,
  input wire logic chipSelectN,
  input wire logic registerSelect,
  input wire logic enableRdN,
  input wire logic readWriteWrN,
  input wire logic [7:0] parallelDataBusIn,
  output logic [7:0] parallelDataBusOut,
  output logic parallelDataBusOe,
  input wire logic serialStrobeN,
  input wire logic shiftClock,
  input wire logic serialIn,
  output logic serialOut,
  output logic serialOutOe,
  output logic commandStrobe,
  output logic [7:0] commandCode
);

  ////////////////////////////////////////////////////////////////////////////
  // Every pin except busWidth4 passes two flops before any logic looks at it.
  logic rstA_q, rstB_q;
  logic [SYNC_W-1:0] syncA_q, syncB_q, pins;

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rstA_q <= 1'b0;
      rstB_q <= 1'b0;
    end else begin
      rstA_q <= 1'b1;
      rstB_q <= rstA_q;
    end
  end

  assign pins = {interfaceModeStrap, chipSelectN, registerSelect, enableRdN, readWriteWrN,
                 serialStrobeN, shiftClock, serialIn, parallelDataBusIn, busStyleI80};

  always_ff @(posedge ref_clk or negedge rstB_q) begin
    if (!rstB_q) begin
      syncA_q <= '0;
      syncB_q <= '0;
    end else begin
      syncA_q <= pins;
      syncB_q <= syncA_q;
    end
  end

  logic strapPar, csN, rsPin, eRd, rwWr, stN, sck, si, i80;
  logic [7:0] dbIn;
  assign {strapPar, csN, rsPin, eRd, rwWr, stN, sck, si, dbIn, i80} = syncB_q;

  ////////////////////////////////////////////////////////////////////////////
  // Host registers, RAM and address counter.
  logic [7:0] charRam [CHAR_DEPTH];
  logic [7:0] glyphRam [GLYPH_DEPTH];
  logic [6:0] ac_q, ac_d;
  logic [7:0] dr_q, dr_d, cmd_q, cmd_d;
  logic glyphSel_q, glyphSel_d, incMode_q, incMode_d, pf_q, pf_d, cmdStb_q, cmdStb_d;
  logic accV, accRs, accRd, ramWr;
  logic [7:0] accData;

  function automatic logic [7:0] readValue(input logic rs, input logic [7:0] dr,
                                           input logic [6:0] ac);
    readValue = rs ? dr : {BUSY_VALUE, ac};
  endfunction

  always_comb begin
    ac_d = ac_q;
    dr_d = dr_q;
    cmd_d = cmd_q;
    glyphSel_d = glyphSel_q;
    incMode_d = incMode_q;
    pf_d = 1'b0;
    cmdStb_d = 1'b0;
    ramWr = 1'b0;
    if (pf_q) begin
      dr_d = glyphSel_q ? glyphRam[ac_q[5:0]] : charRam[ac_q];
    end
    if (accV && !accRd && !accRs) begin
      cmd_d = accData;
      cmdStb_d = 1'b1;
      if (accData[CMD_CHAR_ADDR_BIT]) begin
        ac_d = accData[6:0];
        glyphSel_d = 1'b0;
        pf_d = 1'b1;
      end else if (accData[CMD_GLYPH_ADDR_BIT]) begin
        ac_d = {1'b0, accData[5:0]};
        glyphSel_d = 1'b1;
        pf_d = 1'b1;
      end else if (accData[7:2] == CMD_ENTRY_CODE) begin
        incMode_d = accData[CMD_ENTRY_DIR_BIT];
      end
    end
    if (accV && accRs) begin
      ramWr = !accRd;
      ac_d = incMode_q ? 7'(ac_q + 7'h01) : 7'(ac_q - 7'h01);
      pf_d = accRd;
    end
  end

  always_ff @(posedge ref_clk or negedge rstB_q) begin
    if (!rstB_q) begin
      ac_q <= AC_RESET;
      dr_q <= DR_RESET;
      cmd_q <= CMD_RESET;
      glyphSel_q <= 1'b0;
      incMode_q <= INC_RESET;
      pf_q <= 1'b0;
      cmdStb_q <= 1'b0;
    end else begin
      ac_q <= ac_d;
      dr_q <= dr_d;
      cmd_q <= cmd_d;
      glyphSel_q <= glyphSel_d;
      incMode_q <= incMode_d;
      pf_q <= pf_d;
      cmdStb_q <= cmdStb_d;
    end
  end

  // RAM contents have no reset; only data register writes change them.
  always_ff @(posedge ref_clk) begin
    if (ramWr && glyphSel_q) begin
      glyphRam[ac_q[5:0]] <= accData;
    end
    if (ramWr && !glyphSel_q) begin
      charRam[ac_q] <= accData;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Parallel bus: an access completes on the trailing edge of its strobe.
  logic pAct, pRead, pAct_q, pAct_d, pRs_q, pRs_d, pRd_q, pRd_d, nibHi_q, nibHi_d;
  logic [7:0] pData_q, pData_d, dbOut_q, dbOut_d, rdVal;
  logic [3:0] hiNib_q, hiNib_d;
  logic dbOe_q, dbOe_d, pEnd, pDone;

  assign pAct = strapPar && !csN && (i80 ? (!eRd || !rwWr) : eRd);
  assign pRead = i80 ? !eRd : rwWr;
  assign pEnd = pAct_q && !pAct;
  assign pDone = pEnd && (!busWidth4 || !nibHi_q);
  assign rdVal = readValue(rsPin, dr_q, ac_q);

  always_comb begin
    pAct_d = pAct;
    pRs_d = pAct ? rsPin : pRs_q;
    pRd_d = pAct ? pRead : pRd_q;
    pData_d = pAct ? dbIn : pData_q;
    nibHi_d = nibHi_q;
    hiNib_d = hiNib_q;
    if (!busWidth4 || !strapPar) begin
      nibHi_d = 1'b1;
    end else if (pEnd) begin
      nibHi_d = !nibHi_q;
      hiNib_d = nibHi_q ? pData_q[7:4] : hiNib_q;
    end
    dbOe_d = pAct && pRead;
    if (!busWidth4) begin
      dbOut_d = rdVal;
    end else begin
      dbOut_d = nibHi_q ? {rdVal[7:4], 4'h0} : {rdVal[3:0], 4'h0};
    end
  end

  always_ff @(posedge ref_clk or negedge rstB_q) begin
    if (!rstB_q) begin
      pAct_q <= 1'b0;
      pRs_q <= 1'b0;
      pRd_q <= 1'b0;
      pData_q <= 8'h00;
      nibHi_q <= 1'b1;
      hiNib_q <= 4'h0;
      dbOut_q <= 8'h00;
      dbOe_q <= 1'b0;
    end else begin
      pAct_q <= pAct_d;
      pRs_q <= pRs_d;
      pRd_q <= pRd_d;
      pData_q <= pData_d;
      nibHi_q <= nibHi_d;
      hiNib_q <= hiNib_d;
      dbOut_q <= dbOut_d;
      dbOe_q <= dbOe_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Serial link: first byte of a frame is a header holding select and
  // direction, then data bytes follow while the strobe stays low.
  logic sAct, sckP_q, sckRise, sckFall, hdr_q, hdr_d, sRs_q, sRs_d, sRd_q, sRd_d;
  logic load_q, load_d, sDone, sOut_q, sOe_q;
  logic [2:0] bit_q, bit_d;
  logic [7:0] shIn_q, shIn_d, shOut_q, shOut_d, byteIn;

  assign sAct = !strapPar && !stN;
  assign sckRise = sck && !sckP_q;
  assign sckFall = !sck && sckP_q;
  assign byteIn = {shIn_q[6:0], si};
  assign sDone = sAct && sckRise && (bit_q == SER_LAST) && !hdr_q;

  always_comb begin
    bit_d = bit_q;
    shIn_d = shIn_q;
    shOut_d = shOut_q;
    hdr_d = hdr_q;
    sRs_d = sRs_q;
    sRd_d = sRd_q;
    load_d = load_q;
    if (!sAct) begin
      bit_d = 3'h0;
      hdr_d = 1'b1;
      load_d = 1'b0;
    end else begin
      if (sckRise) begin
        shIn_d = byteIn;
        bit_d = 3'(bit_q + 3'h1);
        if (bit_q == SER_LAST && hdr_q) begin
          hdr_d = 1'b0;
          sRs_d = byteIn[HDR_RS_BIT];
          sRd_d = byteIn[HDR_RD_BIT];
          load_d = byteIn[HDR_RD_BIT];
        end else if (sDone && sRd_q) begin
          load_d = 1'b1;
        end
      end else if (sckFall && bit_q != 3'h0) begin
        shOut_d = {shOut_q[6:0], 1'b0};
      end
      // Wait out the prefetch so the next byte is the fresh one.
      if (load_q && !pf_q && !pf_d) begin
        shOut_d = readValue(sRs_q, dr_q, ac_q);
        load_d = 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rstB_q) begin
    if (!rstB_q) begin
      sckP_q <= 1'b0;
      bit_q <= 3'h0;
      shIn_q <= 8'h00;
      shOut_q <= 8'h00;
      hdr_q <= 1'b1;
      sRs_q <= 1'b0;
      sRd_q <= 1'b0;
      load_q <= 1'b0;
      sOut_q <= 1'b0;
      sOe_q <= 1'b0;
    end else begin
      sckP_q <= sck;
      bit_q <= bit_d;
      shIn_q <= shIn_d;
      shOut_q <= shOut_d;
      hdr_q <= hdr_d;
      sRs_q <= sRs_d;
      sRd_q <= sRd_d;
      load_q <= load_d;
      sOut_q <= shOut_q[7];
      sOe_q <= sAct && !hdr_q && sRd_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // One access stream feeds the register core; the strap picks the source.
  always_comb begin
    if (strapPar) begin
      accV = pDone;
      accRs = pRs_q;
      accRd = pRd_q;
      accData = busWidth4 ? {hiNib_q, pData_q[7:4]} : pData_q;
    end else begin
      accV = sDone;
      accRs = sRs_q;
      accRd = sRd_q;
      accData = byteIn;
    end
  end

  assign parallelDataBusOut = dbOut_q;
  assign parallelDataBusOe = dbOe_q;
  assign serialOut = sOut_q;
  assign serialOutOe = sOe_q;
  assign commandStrobe = cmdStb_q;
  assign commandCode = cmd_q;

endmodule

// [rtl/vhp_pkg.sv]
package vhp_pkg;
  localparam int SYNC_W = 17;
  localparam logic [6:0] AC_RESET = 7'h00;
  localparam logic [7:0] DR_RESET = 8'h00;
  localparam logic [7:0] CMD_RESET = 8'h00;
  localparam logic INC_RESET = 1'b1;
  localparam int CHAR_DEPTH = 128;
  localparam int GLYPH_DEPTH = 64;
  localparam int SER_BITS = 8;
  localparam logic [2:0] SER_LAST = 3'h7;
  localparam int HDR_RS_BIT = 1;
  localparam int HDR_RD_BIT = 0;
  localparam int CMD_CHAR_ADDR_BIT = 7;
  localparam int CMD_GLYPH_ADDR_BIT = 6;
  localparam logic [5:0] CMD_ENTRY_CODE = 6'h01;
  localparam int CMD_ENTRY_DIR_BIT = 1;
  localparam logic BUSY_VALUE = 1'b0;
  localparam real RESET_WAIT_US = 100.0;
  localparam real CLK_MHZ = 10.0;
  localparam int RESET_WAIT_CYC = int'(RESET_WAIT_US * CLK_MHZ);
endpackage

// [bench/vhp_host_model.sv]
`timescale 1ns/1ps
// Host side of the port. Pins of the mode not in use stay at fixed levels, except csN, which serial frames also drive low.
module vhp_host_model (
  input wire logic clk,
  input wire logic i80,
  input wire logic w4,
  input wire logic [7:0] bo,
  input wire logic oe,
  input wire logic so,
  output logic csN,
  output logic rs,
  output logic enRdN,
  output logic rwWrN,
  output logic [7:0] bi,
  output logic stbN,
  output logic sck,
  output logic sdi
);
  logic [7:0] hd;
  // A released bus shows the inverse of the last value so stale data never matches.
  assign bi = oe ? bo : hd;
  initial begin
    csN = 1'b1;
    rs = 1'b0;
    enRdN = 1'b0;
    rwWrN = 1'b1;
    hd = 8'h00;
    stbN = 1'b1;
    sck = 1'b1;
    sdi = 1'b0;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Strobes stay up six clocks because the pins pass two sync flops.
  task automatic beat(input logic r, input logic rd, input logic [7:0] wd, output logic [7:0] rv);
    csN <= 1'b0;
    enRdN <= i80;
    rs <= r;
    rwWrN <= i80 | rd;
    hd <= wd;
    cyc(1);
    if (i80) begin
      enRdN <= ~rd;
      rwWrN <= rd;
    end else begin
      enRdN <= 1'b1;
    end
    cyc(6);
    rv = bo;
    enRdN <= i80;
    rwWrN <= 1'b1;
    cyc(1);
    csN <= 1'b1;
    hd <= ~wd;
    cyc(8);
  endtask
  task automatic acc(input logic r, input logic rd, input logic [7:0] wd, output logic [7:0] rv);
    logic [7:0] hi;
    logic [7:0] lo;
    if (w4) begin
      beat(r, rd, {wd[7:4], 4'h0}, hi);
      beat(r, rd, {wd[3:0], 4'h0}, lo);
      rv = {hi[7:4], lo[7:4]};
    end else begin
      beat(r, rd, wd, rv);
    end
  endtask
  task automatic sbyte(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      sck <= 1'b0;
      sdi <= tx[i];
      cyc(4);
      sck <= 1'b1;
      // Sample mid high phase; the output bit only moves after the next fall.
      cyc(2);
      rx[i] = so;
      cyc(2);
    end
    cyc(10);
  endtask
  task automatic sframe(input logic [7:0] hdr, input logic [7:0] tx, output logic [7:0] rx);
    logic [7:0] dummy;
    csN <= 1'b0;
    stbN <= 1'b0;
    cyc(3);
    sbyte(hdr, dummy);
    sbyte(tx, rx);
    stbN <= 1'b1;
    csN <= 1'b1;
    sdi <= 1'b0;
    cyc(8);
  endtask
endmodule

// [bench/vhp_port_props.sv]
`timescale 1ns/1ps
module vhp_port_props (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic interfaceModeStrap,
  input wire logic busWidth4,
  input wire logic registerSelect,
  input wire logic readWriteWrN,
  input wire logic serialStrobeN,
  input wire logic [7:0] parallelDataBusOut,
  input wire logic parallelDataBusOe,
  input wire logic serialOutOe,
  input wire logic commandStrobe,
  input wire logic [7:0] commandCode
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  property p_serNoBus; (!interfaceModeStrap)[*6] |-> !parallelDataBusOe; endproperty
  a_serNoBus: assert property (p_serNoBus) else $error("bus out in serial mode");
  property p_parNoSer; interfaceModeStrap[*6] |-> !serialOutOe; endproperty
  a_parNoSer: assert property (p_parNoSer) else $error("serial out in bus mode");
  property p_busy;
    parallelDataBusOe && !busWidth4 && !registerSelect && !$past(registerSelect, 8)
      |-> !parallelDataBusOut[7];
  endproperty
  a_busy: assert property (p_busy) else $error("busy bit set");
  property p_nib; busWidth4 && parallelDataBusOe |-> parallelDataBusOut[3:0] == 4'h0; endproperty
  a_nib: assert property (p_nib) else $error("low nibble not zero");
  property p_pulse; commandStrobe |=> !commandStrobe; endproperty
  a_pulse: assert property (p_pulse) else $error("command strobe too long");
  property p_cause; !$stable(commandCode) |-> commandStrobe || $past(commandStrobe); endproperty
  a_cause: assert property (p_cause) else $error("command changed alone");
  property p_frame; serialStrobeN[*6] |-> !serialOutOe; endproperty
  a_frame: assert property (p_frame) else $error("serial out outside frame");
  property p_wrQuiet; (!readWriteWrN && interfaceModeStrap)[*6] |-> !parallelDataBusOe; endproperty
  a_wrQuiet: assert property (p_wrQuiet) else $error("bus out on write");
  c_cmd: cover property (commandStrobe);
  c_nib: cover property (busWidth4 && parallelDataBusOe);
  c_ser: cover property (serialOutOe);
endmodule
bind vfd_host_register_port vhp_port_props props_u (.*);

// [bench/testbench.sv]
`timescale 1ns/1ps
module testbench import vhp_pkg::*;;
  logic ref_clk, resetn, interfaceModeStrap, busStyleI80, busWidth4, chipSelectN;
  logic registerSelect, enableRdN, readWriteWrN, serialStrobeN, shiftClock, serialIn;
  logic parallelDataBusOe, serialOut, serialOutOe, commandStrobe;
  logic [7:0] parallelDataBusIn, parallelDataBusOut, commandCode, rv;
  int bad_count = 0;
  int compares = 0;
  int cycles = 0;
  vfd_host_register_port dut_u (.*);
  vhp_host_model host_u (.clk(ref_clk), .i80(busStyleI80), .w4(busWidth4),
    .bo(parallelDataBusOut), .oe(parallelDataBusOe), .so(serialOut), .csN(chipSelectN),
    .rs(registerSelect), .enRdN(enableRdN), .rwWrN(readWriteWrN), .bi(parallelDataBusIn),
    .stbN(serialStrobeN), .sck(shiftClock), .sdi(serialIn));
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic final_report();
    $display("Comparisons %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic wr(input logic r, input logic [7:0] d);
    host_u.acc(r, 1'b0, d, rv);
  endtask
  task automatic rd(input string what, input logic r, input logic [7:0] exp);
    host_u.acc(r, 1'b1, 8'h00, rv);
    check(what, rv, exp);
  endtask
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      bad_count++;
      final_report();
    end
  end
  initial begin
    resetn = 1'b0;
    interfaceModeStrap = 1'b1;
    busStyleI80 = 1'b0;
    busWidth4 = 1'b0;
    repeat (2) @(posedge ref_clk);
    resetn <= 1'b1;
    repeat (RESET_WAIT_CYC) @(posedge ref_clk);
    wr(1'b0, 8'h85);
    check("command", commandCode, 8'h85);
    wr(1'b1, 8'hA1);
    wr(1'b1, 8'hB2);
    rd("status", 1'b0, 8'h07);
    wr(1'b0, 8'h85);
    rd("data0", 1'b1, 8'hA1);
    rd("data1", 1'b1, 8'hB2);
    wr(1'b0, 8'h04);
    wr(1'b1, 8'hC3);
    rd("down", 1'b0, 8'h06);
    wr(1'b0, 8'h06);
    $display("Test m68 done");
    busStyleI80 <= 1'b1;
    @(posedge ref_clk);
    wr(1'b0, 8'h42);
    wr(1'b1, 8'h3C);
    wr(1'b0, 8'h42);
    rd("glyph", 1'b1, 8'h3C);
    rd("status2", 1'b0, 8'h03);
    $display("Test i80 done");
    busWidth4 <= 1'b1;
    @(posedge ref_clk);
    wr(1'b0, 8'h85);
    rd("nibbles", 1'b1, 8'hA1);
    rd("status4", 1'b0, 8'h06);
    $display("Test nibble done");
    busWidth4 <= 1'b0;
    interfaceModeStrap <= 1'b0;
    repeat (10) @(posedge ref_clk);
    host_u.sframe(8'h00, 8'h86, rv);
    check("ser command", commandCode, 8'h86);
    host_u.sframe(8'h03, 8'h00, rv);
    check("ser data", rv, 8'hB2);
    $display("Test serial done");
    final_report();
  end
endmodule
